/* seerw_pkg.sv */
package seerw_pkg;
	// ----------------------------------------------------------------
	// geometry and protocol constants
	// ----------------------------------------------------------------
	localparam int          ADDR_W        = 8;
	localparam int          DATA_W        = 8;
	localparam int          MEM_DEPTH     = 256;
	localparam int          COL_W         = 4;
	localparam logic [3:0]  DEV_TYPE_CODE = 4'hA;
	localparam logic [2:0]  BIT_LAST      = 3'h7;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int          CLK_PERIOD_NS = 8;
	localparam int          WR_TIME_MS    = 5;
	localparam int          WR_CYCLES     = (WR_TIME_MS * 1000000) / CLK_PERIOD_NS;
	localparam int          PUP_TIME_US   = 100;
	localparam int          PUP_CYCLES    = (PUP_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          CNT_W         = 20;

	typedef enum logic [2:0] {
		SEERW_IDLE,
		SEERW_DEV,
		SEERW_WADDR,
		SEERW_WDATA,
		SEERW_RDATA,
		SEERW_MACK,
		SEERW_IGNORE
	} seerw_state_t;

	// bus view after synchronisation and edge finding
	typedef struct packed {
		logic scl_rise;
		logic scl_fall;
		logic start;
		logic stop;
		logic sda;
	} seerw_bus_t;
endpackage

/* seerw_engine.sv */
`timescale 1ns/1ps
// Functional notes
// R01 - start/stop are data edges while clock high
// R02 - address byte 1010, chip select, direction
// R03 - write protect high blocks array programming
// R04 - acknowledge matching write address on clock 9
// R05 - acknowledge word address on clock 18
// R06 - acknowledge data on clock 27, then stop
// R07 - stop after write starts self-timed programming
// R08 - page write acks every ninth clock
// R09 - page load increments only low column bits
// R10 - page load starts at any column
// R11 - column wraps, seventeenth byte overwrites first
// R12 - no acknowledge while programming runs
// R13 - read address byte has direction bit one
// R14 - counter holds last address plus one
// R15 - current read: one byte, no ack, stop
// R16 - controller ack requests next sequential byte
// R17 - read counter rolls over past top
// R18 - random read via dummy write then restart
// R19 - restart after word address abandons programming
// R20 - commands ignored while power-on reset active
// R21 - controller waits 100 us after power-up
module seerw_engine
	import seerw_pkg::*;
#(
	parameter int WR_CNT  = WR_CYCLES,        // programming length, cycles
	parameter int POR_CNT = PUP_CYCLES        // power-on hold, cycles
)(
	input  wire logic       i_sys_clk,         // system clock 125 MHz
	input  wire logic       i_rstn,            // async reset, active low
	input  wire logic       i_scl,             // serial clock pin
	input  wire logic       i_sda,             // serial data pin, input side
	output logic            o_sda,             // serial data output level
	output logic            o_sda_oe,          // high while pulling data low
	input  wire logic [2:0] i_chip_select_pins, // address strap pins
	input  wire logic       i_write_protect,   // high inhibits programming
	output logic            o_busy             // self-timed programming active
);
	// ----------------------------------------------------------------
	// reset release and pin synchronisers
	// ----------------------------------------------------------------
	logic [1:0] rst_sync_q;
	logic       rstn;
	logic [1:0] scl_sync_q, sda_sync_q;
	logic       scl_q, sda_q;
	logic [2:0] cs_meta_q, cs_pins_q;
	logic [1:0] wp_sync_q;
	logic       wp_on;
	seerw_bus_t bus;

	// release reset through two flops
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) rst_sync_q <= 2'h0;
		else         rst_sync_q <= {rst_sync_q[0], 1'b1};
	end
	assign rstn = rst_sync_q[1];

	// pins pass two flops before use; third stage for edges
	always_ff @(posedge i_sys_clk or negedge rstn) begin
		if (!rstn) begin
			scl_sync_q <= 2'h3;
			sda_sync_q <= 2'h3;
			scl_q      <= 1'b1;
			sda_q      <= 1'b1;
			cs_meta_q  <= 3'h0;
			cs_pins_q  <= 3'h0;
			wp_sync_q  <= 2'h0;
		end else begin
			scl_sync_q <= {scl_sync_q[0], i_scl};
			sda_sync_q <= {sda_sync_q[0], i_sda};
			scl_q      <= scl_sync_q[1];
			sda_q      <= sda_sync_q[1];
			cs_meta_q  <= i_chip_select_pins;
			cs_pins_q  <= cs_meta_q;
			wp_sync_q  <= {wp_sync_q[0], i_write_protect};
		end
	end
	// straps and protect pin are asynchronous levels as well
	assign wp_on = wp_sync_q[1];

	// edge finding on the synchronised copies
	always_comb begin
		bus.scl_rise = scl_sync_q[1] & ~scl_q;
		bus.scl_fall = ~scl_sync_q[1] & scl_q;
		bus.start    = scl_sync_q[1] & scl_q & sda_q & ~sda_sync_q[1];   // see R01
		bus.stop     = scl_sync_q[1] & scl_q & ~sda_q & sda_sync_q[1];   // see R01
		bus.sda      = sda_sync_q[1];
	end

	// ----------------------------------------------------------------
	// power-on hold
	// ----------------------------------------------------------------
	logic [CNT_W-1:0] por_cnt_q;
	logic             por_done;
	assign por_done = (por_cnt_q == CNT_W'(POR_CNT));

	// stands in for the supply threshold detector
	always_ff @(posedge i_sys_clk or negedge rstn) begin
		if (!rstn)          por_cnt_q <= '0;
		else if (!por_done) por_cnt_q <= por_cnt_q + 1'b1;   // see R20
	end

	// ----------------------------------------------------------------
	// array, page buffer and address counter
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] mem_q [MEM_DEPTH];
	logic [DATA_W-1:0] page_q [16];
	logic [15:0]       page_vld_q;
	logic [ADDR_W-1:0] addr_q;
	logic [CNT_W-1:0]  wr_cnt_q;
	logic              busy_q;
	logic              prog_go;

	seerw_state_t      state_q;
	logic [3:0]        bit_q;
	logic [DATA_W-1:0] shift_q;
	logic              ack_phase_q;
	logic              ack_drive_q;
	logic              rd_dir_q;
	logic              have_data_q;
	logic              got_byte;
	logic              master_ack_q;
	logic [DATA_W-1:0] rd_byte_q;

	assign o_busy = busy_q;

	// programming timer; no bus input can stop it
	always_ff @(posedge i_sys_clk or negedge rstn) begin
		if (!rstn) begin
			busy_q   <= 1'b0;
			wr_cnt_q <= '0;
		end else if (prog_go) begin
			busy_q   <= 1'b1;                                         // see R07
			wr_cnt_q <= '0;
		end else if (busy_q) begin
			wr_cnt_q <= wr_cnt_q + 1'b1;
			if (wr_cnt_q == CNT_W'(WR_CNT - 1)) busy_q <= 1'b0;        // see R07
		end
	end

	// array update: only loaded page buffer entries commit at programming start
	// array has no reset on purpose, contents are not control state
	always_ff @(posedge i_sys_clk) begin
		for (int i = 0; i < 16; i++) begin
			if (prog_go && page_vld_q[i])
				mem_q[{addr_q[ADDR_W-1:COL_W], COL_W'(i)}] <= page_q[i];
		end
	end

	// ----------------------------------------------------------------
	// bit engine
	// ----------------------------------------------------------------
	assign got_byte = bus.scl_rise && !ack_phase_q && bit_q == 4'(BIT_LAST);

	// prog starts only at a stop after data; write protect blocks it
	assign prog_go = bus.stop && state_q == SEERW_WDATA && have_data_q
	                 && !wp_on && !busy_q;                        // see R03 R06

	// command sequencer
	always_ff @(posedge i_sys_clk or negedge rstn) begin
		if (!rstn) begin
			state_q      <= SEERW_IDLE;
			bit_q        <= '0;
			shift_q      <= '0;
			ack_phase_q  <= 1'b0;
			ack_drive_q  <= 1'b0;
			rd_dir_q     <= 1'b0;
			have_data_q  <= 1'b0;
			master_ack_q <= 1'b0;
			addr_q       <= '0;
			rd_byte_q    <= '0;
			page_vld_q   <= '0;
		end else if (!por_done) begin
			state_q <= SEERW_IDLE;                                    // see R20
		end else if (bus.start) begin
			// a restart drops pending page data, keeps the address  see R19 R18
			state_q     <= SEERW_DEV;
			bit_q       <= '0;
			ack_phase_q <= 1'b0;
			ack_drive_q <= 1'b0;
			have_data_q <= 1'b0;
			page_vld_q  <= '0;
		end else if (bus.stop) begin
			state_q     <= SEERW_IDLE;
			ack_drive_q <= 1'b0;
			ack_phase_q <= 1'b0;
			page_vld_q  <= '0;
		end else begin
			case (state_q)
				SEERW_IDLE, SEERW_IGNORE: begin
					ack_drive_q <= 1'b0;
				end
				default: begin
					if (bus.scl_rise && !ack_phase_q) begin
						shift_q <= {shift_q[DATA_W-2:0], bus.sda};
						bit_q   <= bit_q + 4'h1;
					end
					if (bus.scl_rise && ack_phase_q && state_q == SEERW_MACK)
						master_ack_q <= ~bus.sda;                     // see R16
					if (got_byte) begin
						ack_phase_q <= 1'b1;
						case (state_q)
							SEERW_DEV: begin
								// busy device stays silent   see R02 R12 R13
								if ({shift_q[6:3], shift_q[2:0]} ==
								    {DEV_TYPE_CODE, cs_pins_q} && !busy_q) begin
									rd_dir_q <= bus.sda;
									state_q  <= bus.sda ? SEERW_RDATA : SEERW_WADDR;
								end else begin
									state_q <= SEERW_IGNORE;
								end
							end
							SEERW_WADDR: begin
								addr_q  <= {shift_q[6:0], bus.sda};    // see R05 R10
								state_q <= SEERW_WDATA;
							end
							SEERW_WDATA: begin
								page_q[addr_q[COL_W-1:0]]     <= {shift_q[6:0], bus.sda};
								page_vld_q[addr_q[COL_W-1:0]] <= 1'b1; // see R11
								// column only; page bits stay     see R09
								addr_q[COL_W-1:0] <= addr_q[COL_W-1:0] + 1'b1;
								have_data_q <= 1'b1;
							end
							default: begin
							end
						endcase
					end
					// falling edge after 8th bit: drive ack or release
					if (bus.scl_fall && ack_phase_q && bit_q == 4'h8) begin
						bit_q <= 4'h9;
						case (state_q)
							SEERW_WADDR, SEERW_WDATA: ack_drive_q <= 1'b1; // see R04 R05 R06 R08
							SEERW_RDATA: ack_drive_q <= rd_dir_q;     // see R13
							default: ack_drive_q <= 1'b0;
						endcase
					end
					// falling edge that ends the ninth clock
					if (bus.scl_fall && ack_phase_q && bit_q == 4'h9) begin
						ack_drive_q <= 1'b0;
						ack_phase_q <= 1'b0;
						bit_q       <= '0;
						if (state_q == SEERW_RDATA || state_q == SEERW_MACK) begin
							if (state_q == SEERW_MACK && !master_ack_q) begin
								state_q <= SEERW_IGNORE;                   // see R15
							end else begin
								// load byte, advance counter with wrap  see R14 R17
								rd_byte_q <= mem_q[addr_q];
								addr_q    <= addr_q + 1'b1;
								state_q   <= SEERW_MACK;
								rd_dir_q  <= 1'b0;
							end
						end
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// data pin driver: ack low, or read data bit by bit
	// ----------------------------------------------------------------
	logic sda_out_q;
	logic fall_q;

	// line moves the cycle after a clock fall, or is released at once in idle or power-on hold; a change while the
	// clock is high would read as a start or stop on the bus
	always_ff @(posedge i_sys_clk or negedge rstn) begin
		if (!rstn) begin
			fall_q    <= 1'b0;
			sda_out_q <= 1'b1;
		end else begin
			fall_q <= bus.scl_fall;
			if (!por_done || state_q == SEERW_IDLE) begin
				sda_out_q <= 1'b1;                                    // see R20
			end else if (fall_q) begin
				if (ack_drive_q)
					sda_out_q <= 1'b0;
				else if (state_q == SEERW_MACK && !ack_phase_q && bit_q < 4'h8)
					sda_out_q <= rd_byte_q[3'(BIT_LAST - bit_q[2:0])];   // see R15 R16
				else
					sda_out_q <= 1'b1;
			end
		end
	end
	assign o_sda    = 1'b0;
	assign o_sda_oe = ~sda_out_q;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	int ack_cnt_q;
	always_ff @(posedge i_sys_clk or negedge rstn) begin
		if (!rstn)        ack_cnt_q <= 0;
		else if (busy_q)  ack_cnt_q <= ack_cnt_q + 1;
		else              ack_cnt_q <= 0;
	end

	busy_no_ack_a: assert property (@(posedge i_sys_clk) disable iff (!rstn)
		busy_q && got_byte && state_q == SEERW_DEV |=> state_q == SEERW_IGNORE) else $error("ack while programming"); // see R12
	prog_wp_a: assert property (@(posedge i_sys_clk) disable iff (!rstn)
		wp_on |-> !prog_go) else $error("programming under write protect"); // see R03
	prog_start_a: assert property (@(posedge i_sys_clk) disable iff (!rstn)
		prog_go |=> busy_q) else $error("programming did not start"); // see R07
	prog_len_a: assert property (@(posedge i_sys_clk) disable iff (!rstn)
		ack_cnt_q <= WR_CNT) else $error("programming too long"); // see R07
	por_quiet_a: assert property (@(posedge i_sys_clk) disable iff (!rstn)
		!por_done |-> state_q == SEERW_IDLE && !o_sda_oe) else $error("active before power-on"); // see R20
	col_wrap_a: assert property (@(posedge i_sys_clk) disable iff (!rstn)
		got_byte && state_q == SEERW_WDATA |=>
		addr_q[ADDR_W-1:COL_W] == $past(addr_q[ADDR_W-1:COL_W])) else $error("page bits moved"); // see R09
	rd_inc_a: assert property (@(posedge i_sys_clk) disable iff (!rstn)
		$rose(state_q == SEERW_MACK) |-> addr_q == $past(addr_q) + 8'h01) else $error("counter not advanced"); // see R14
	stop_idle_a: assert property (@(posedge i_sys_clk) disable iff (!rstn)
		bus.stop && por_done |=> state_q == SEERW_IDLE) else $error("stop not honoured"); // see R01
endmodule

/* seerw_host_model.sv */
`timescale 1ns/1ps
module seerw_host_model (
	input  wire logic i_sys_clk, // system clock, paces the bus
	input  wire logic i_sda,     // resolved data line
	output logic      o_scl,     // serial clock, stands high between frames
	output logic      o_sda_oe   // high while pulling data low
);
	// ----------------------------------------------------------------
	// bus phases
	// ----------------------------------------------------------------
	initial begin
		o_scl = 1'b1;
		o_sda_oe = 1'b0;
	end
	// waits n system clocks; a bit is ten of them, an 80 ns clock
	task automatic tick(input int n);
		repeat (n) @(negedge i_sys_clk);
	endtask
	// data falls while clock high; a repeated start releases first
	task automatic start();
		tick(1);
		o_sda_oe = 1'b0;
		tick(5);
		o_scl = 1'b1;
		tick(4);
		o_sda_oe = 1'b1;
		tick(4);
		o_scl = 1'b0;
	endtask
	// data rises while clock high, bus then left free a while
	task automatic stop();
		tick(1);
		o_sda_oe = 1'b1;
		tick(5);
		o_scl = 1'b1;
		tick(4);
		o_sda_oe = 1'b0;
		tick(6);
	endtask
	// data set just after the fall, level taken at the end of high
	// low phase is longer so the device's answer settles before rise
	task automatic bit_cyc(input logic drive_low, output logic level);
		tick(1);
		o_sda_oe = drive_low;
		tick(5);
		o_scl = 1'b1;
		tick(4);
		level = i_sda;
		o_scl = 1'b0;
	endtask
	// msb first, then the device's answer on the ninth clock
	task automatic wbyte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_cyc(~b[i], s);
		end
		bit_cyc(1'b0, s);
		ack = ~s;
	endtask
	// line released for the data, our ack asks for one more byte
	task automatic rbyte(input logic mack, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_cyc(1'b0, s);
			b[i] = s;
		end
		bit_cyc(mack, s);
	endtask
endmodule

/* seerw_engine_tb.sv */
`timescale 1ns/1ps
module seerw_engine_tb import seerw_pkg::*;;
	localparam logic [2:0] CS = 3'h5;
	logic       clk, rstn, wp, scl, host_oe, dut_sda, dut_oe, busy, ack;
	logic [7:0] exp_mem [256];
	logic [7:0] rd_b;
	int         miscompares, check_count;
	// open drain with pull-up: any party pulling low wins
	wire        sda = ~(host_oe | (dut_oe & ~dut_sda));

	// short counts keep the run brief; both still exceed a command frame
	seerw_engine #(.WR_CNT(600), .POR_CNT(400)) DUT (
		.i_sys_clk(clk), .i_rstn(rstn), .i_scl(scl), .i_sda(sda), .o_sda(dut_sda),
		.o_sda_oe(dut_oe), .i_chip_select_pins(CS), .i_write_protect(wp), .o_busy(busy));
	seerw_host_model HOST (.i_sys_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_oe(host_oe));

	// ----------------------------------------------------------------
	// checking and access tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic final_report();
		if (miscompares == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic wait_idle();
		int k = 0;
		while (busy !== 1'b0 && k < 2000) begin
			@(negedge clk);
			k++;
		end
		if (k == 2000) begin
			miscompares++;
			final_report();
		end
	endtask
	task automatic addr(input logic dir, input logic [2:0] cs, input logic exp_ack);
		HOST.start();
		HOST.wbyte({DEV_TYPE_CODE, cs, dir}, ack);
		chk(8'(ack), 8'(exp_ack));
	endtask
	// write n bytes from d0 upward, then poll while programming runs
	task automatic wr(input logic [7:0] a, input int n, input logic [7:0] d0);
		addr(1'b0, CS, 1'b1);
		HOST.wbyte(a, ack);
		chk(8'(ack), 8'h01);
		for (int i = 0; i < n; i++) begin
			HOST.wbyte(d0 + 8'(i), ack);
			chk(8'(ack), 8'h01);
			if (!wp) exp_mem[{a[7:4], a[3:0] + 4'(i)}] = d0 + 8'(i);
		end
		HOST.stop();
		// a protected write never starts programming, so it answers
		addr(1'b0, CS, wp);
		chk(8'(busy), 8'(!wp));
		HOST.stop();
		wait_idle();
	endtask
	// optional dummy write, then read n bytes, nack on the last
	task automatic rd(input logic [7:0] a, input int n, input logic setp);
		if (setp) begin
			addr(1'b0, CS, 1'b1);
			HOST.wbyte(a, ack);
			chk(8'(ack), 8'h01);
		end
		addr(1'b1, CS, 1'b1);
		for (int i = 0; i < n; i++) begin
			HOST.rbyte(i < n - 1, rd_b);
			chk(rd_b, exp_mem[8'(a + i)]);
		end
		HOST.stop();
	endtask

	// ----------------------------------------------------------------
	// clock and main sequence
	// ----------------------------------------------------------------
	always #4 clk = ~clk;
	initial begin
		clk = 1'b0;
		rstn = 1'b0;
		wp = 1'b0;
		miscompares = 0;
		check_count = 0;
		repeat (3) @(negedge clk);
		rstn = 1'b1;
		addr(1'b0, CS, 1'b0);
		HOST.stop();
		repeat (400) @(negedge clk);
		addr(1'b0, ~CS, 1'b0);
		HOST.stop();
		wr(8'h10, 1, 8'h5A);
		rd(8'h10, 1, 1'b1);
		chk(8'(busy), 8'h00);
		wp = 1'b1;
		wr(8'h10, 1, 8'h99);
		wp = 1'b0;
		rd(8'h10, 1, 1'b1);
		wr(8'h2E, 18, 8'hC0);
		rd(8'h20, 15, 1'b1);
		rd(8'h2F, 1, 1'b0);
		wr(8'hFF, 1, 8'h3C);
		wr(8'h00, 1, 8'hC3);
		rd(8'hFF, 2, 1'b1);
		final_report();
	end
endmodule
